// ==== src/ipmc_ctrl.sv ====
// module: interrupt arbitration and low-power mode control
`timescale 1ns/100ps
module ipmc_ctrl
    import ipmc_pkg::*;
#(
    parameter int PINS       = 8,
    parameter int STAB_COUNT = IPMC_STAB_CYCLES
)(
    input  wire logic            i_clock,
    input  wire logic            i_rst,
    input  wire logic [PINS-1:0] i_group_zero_pins,
    input  wire logic [PINS-1:0] i_group_zero_enable,
    input  wire logic [PINS-1:0] i_group_one_pins,
    input  wire logic [PINS-1:0] i_group_one_enable,
    input  wire logic [1:0]      i_group_zero_sens,
    input  wire logic [1:0]      i_group_one_sens,
    input  wire logic [13:0]     i_periph_flag_set,
    input  wire logic [13:0]     i_periph_enable,
    input  wire logic [13:0]     i_flag_write_zero,
    input  wire logic [13:0]     i_status_access,
    input  wire logic [13:0]     i_assoc_access,
    input  wire logic            i_trap_instr,
    input  wire logic            i_wait_for_irq_instruction,
    input  wire logic            i_halt_instr,
    input  wire logic            i_iret,
    input  wire logic            i_vector_fetch,
    input  wire logic            i_slow_mode_enable,
    input  wire logic [1:0]      i_slow_prescaler_select,
    output logic                 o_mask_bit,
    output logic                 o_irq_req,
    output logic [15:0]          o_vector,
    output logic [13:0]          o_periph_flags,
    output logic [5:0]           o_clock_div,
    output logic                 o_cpu_stopped,
    output logic                 o_osc_on,
    output logic                 o_slow_wait
);
    ipmc_state_type  state;
    ipmc_state_type  next_state;
    logic [PINS-1:0] sync_a [2];
    logic [PINS-1:0] sync_b [2];
    logic [1:0]      nand_prev;
    logic [1:0]      ext_latch;
    logic [13:0]     flags;
    logic [13:0]     armed;
    logic            boot;
    logic [12:0]     stab_cnt;
    logic [3:0]      serv_slot;
    logic            serv_trap;
    logic            serv_reset;

    // nand of enabled pins per group
    wire logic [1:0] grp_nand;
    assign grp_nand[0] = ~&(sync_b[0] | ~i_group_zero_enable);
    assign grp_nand[1] = ~&(sync_b[1] | ~i_group_one_enable);
    wire logic [1:0] any_en;
    assign any_en[0] = |i_group_zero_enable;
    assign any_en[1] = |i_group_one_enable;

    function automatic logic [1:0] detect(input logic [1:0] sens,
                                          input logic cur,
                                          input logic prev);
        logic rise;
        logic fall;
        rise = cur & ~prev;
        fall = ~cur & prev;
        case (sens)
            IPMC_SENS_FALL_LOW: detect = {1'b1, ~cur};
            IPMC_SENS_RISE:     detect = {1'b0, rise};
            IPMC_SENS_FALL:     detect = {1'b0, fall};
            default:            detect = {1'b0, rise | fall};
        endcase
    endfunction

    // detector result per group: {level mode, event}
    wire logic [1:0] det0;
    wire logic [1:0] det1;
    assign det0 = detect(i_group_zero_sens, grp_nand[0], nand_prev[0]);
    assign det1 = detect(i_group_one_sens, grp_nand[1], nand_prev[1]);
    wire logic [1:0] ext_event;
    assign ext_event = {det1[0] & any_en[1], det0[0] & any_en[0]};
    wire logic [1:0] ext_level;
    assign ext_level = {det1[1], det0[1]};
    wire logic [1:0] ext_pend;
    assign ext_pend = ext_latch | (ext_level & ext_event);

    // peripheral clearing sequence
    wire logic [13:0] clear_seq;
    assign clear_seq = armed & i_assoc_access;
    wire logic [13:0] flag_clr;
    assign flag_clr = i_flag_write_zero | clear_seq;

    // pending slots: peripheral flags need enable, unused slots never raise
    wire logic [13:0] pend;
    assign pend = ({12'h000, ext_pend} | (flags & i_periph_enable))
                  & IPMC_USED_MASK;
    wire logic        any_pend;
    assign any_pend = |pend;
    wire logic        halt_wake;
    assign halt_wake = |(pend & IPMC_HALT_WAKE_MASK);

    function automatic logic [3:0] first_slot(input logic [13:0] p);
        logic [3:0] idx;
        idx = 4'h0;
        for (int k = IPMC_SLOTS - 1; k >= 0; k--)
        begin
            if (p[k])
            begin
                idx = 4'(k);
            end
        end
        return idx;
    endfunction

    wire logic [3:0]  win_slot;
    assign win_slot = first_slot(pend);
    wire logic [15:0] win_vector;
    assign win_vector = IPMC_VEC_SLOT0
                        - {11'h000, win_slot, 1'b0};
    wire logic        take_irq;
    assign take_irq = any_pend & ~o_mask_bit;

    wire logic [5:0]  slow_div;
    assign slow_div = 6'h04 << i_slow_prescaler_select;
    wire logic [5:0]  next_div;
    assign next_div = i_slow_mode_enable ? slow_div : IPMC_DIV_RUN;

    wire logic [12:0] stab_last;
    assign stab_last = 13'(STAB_COUNT - 1);

    always_comb
    begin
        next_state = state;
        case (state)
            IPMC_RUN:
            begin
                if (i_trap_instr | take_irq)
                    next_state = IPMC_VECT;
                else if (i_wait_for_irq_instruction)
                    next_state = IPMC_WAIT;
                else if (i_halt_instr)
                    next_state = IPMC_HALT;
            end
            IPMC_WAIT:
            begin
                if (any_pend)
                    next_state = IPMC_VECT;
            end
            IPMC_HALT:
            begin
                if (halt_wake)
                    next_state = IPMC_STAB;
            end
            IPMC_STAB:
            begin
                if (stab_cnt == stab_last)
                    next_state = IPMC_VECT;
            end
            IPMC_VECT:
            begin
                if (i_vector_fetch)
                    next_state = IPMC_RUN;
            end
            default: next_state = IPMC_RUN;
        endcase
    end

    // vector phase events
    wire logic entering;
    assign entering = (state == IPMC_VECT) & i_vector_fetch;
    wire logic start_vect;
    assign start_vect = (state != IPMC_VECT) & (next_state == IPMC_VECT);
    wire logic from_run;
    assign from_run = (state == IPMC_RUN) & (next_state == IPMC_VECT);
    wire logic sleep_cmd;
    assign sleep_cmd = (state == IPMC_RUN)
                       & (i_wait_for_irq_instruction | i_halt_instr);

    // edge latch per group: set by an edge, cleared on its own vector
    wire logic [1:0] ext_set;
    wire logic [1:0] ext_clear;
    wire logic [1:0] next_ext_latch;

    generate
        for (genvar g = 0; g < 2; g++)
        begin : g_group
            assign ext_set[g] = ext_event[g] & ~ext_level[g];
            assign ext_clear[g] = entering & ~serv_trap & ~serv_reset
                                  & (serv_slot == 4'(g));
            assign next_ext_latch[g] = ext_set[g]
                                       | (ext_latch[g] & ~ext_clear[g]);

            // pin synchronisers, two flops per group
            always_ff @(posedge i_clock)
            begin
                sync_a[g] <= (g == 0) ? i_group_zero_pins
                                      : i_group_one_pins;
                sync_b[g] <= sync_a[g];
            end
        end
    endgenerate

    // peripheral flags and the clear sequence arming
    wire logic [13:0] next_flags;
    assign next_flags = (flags & ~flag_clr)
                        | i_periph_flag_set;
    wire logic [13:0] next_armed;
    assign next_armed = (armed | (i_status_access & flags))
                        & ~i_assoc_access;
    // stabilisation count runs only in stab
    wire logic [12:0] next_stab_cnt;
    assign next_stab_cnt = (state == IPMC_STAB) ? stab_cnt + 13'h0001
                                                : 13'h0000;

    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            state     <= IPMC_VECT;
            nand_prev <= 2'h0;
            ext_latch <= 2'h0;
            flags     <= 14'h0000;
            armed     <= 14'h0000;
            stab_cnt  <= 13'h0000;
        end
        else
        begin
            state     <= next_state;
            nand_prev <= grp_nand;
            ext_latch <= next_ext_latch;
            flags     <= next_flags;
            armed     <= next_armed;
            stab_cnt  <= next_stab_cnt;
        end
    end

    // source captured as a vector is requested
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            serv_slot  <= 4'h0;
            serv_trap  <= 1'b0;
            serv_reset <= 1'b1;
        end
        else if (start_vect)
        begin
            serv_trap  <= from_run & i_trap_instr;
            serv_reset <= 1'b0;
            serv_slot  <= win_slot;
        end
    end

    // global mask: set on entry, cleared by return or sleep
    wire logic next_mask;
    assign next_mask = entering ? 1'b1
                     : (i_iret | sleep_cmd) ? 1'b0
                     : o_mask_bit;

    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            boot       <= 1'b1;
            o_mask_bit <= 1'b1;
        end
        else
        begin
            boot       <= boot & ~entering;
            o_mask_bit <= next_mask;
        end
    end

    // next values of the outputs toward the cpu core
    wire logic        next_irq_req;
    assign next_irq_req = (next_state == IPMC_VECT)
                          & ~(boot & (state == IPMC_VECT));
    wire logic [15:0] next_vector;
    assign next_vector = (state == IPMC_VECT & serv_reset) ? IPMC_VEC_RESET
                       : (from_run & i_trap_instr) ? IPMC_VEC_TRAP
                       : start_vect ? win_vector
                       : o_vector;
    wire logic        next_stopped;
    assign next_stopped = (next_state == IPMC_WAIT)
                          | (next_state == IPMC_HALT)
                          | (next_state == IPMC_STAB);

    wire logic        next_slow_wait;
    assign next_slow_wait = (next_state == IPMC_WAIT)
                            & i_slow_mode_enable;
    wire logic        next_osc_on;
    assign next_osc_on = next_state != IPMC_HALT;

    // registered outputs toward the cpu core
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            o_irq_req      <= 1'b0;
            o_vector       <= IPMC_VEC_RESET;
            o_periph_flags <= 14'h0000;
            o_clock_div    <= IPMC_DIV_RUN;
            o_cpu_stopped  <= 1'b0;
            o_osc_on       <= 1'b1;
            o_slow_wait    <= 1'b0;
        end
        else
        begin
            o_irq_req      <= next_irq_req;
            o_vector       <= next_vector;
            o_periph_flags <= flags;
            o_clock_div    <= next_div;
            o_cpu_stopped  <= next_stopped;
            o_osc_on       <= next_osc_on;
            o_slow_wait    <= next_slow_wait;
        end
    end
endmodule

// ==== src/ipmc_pkg.sv ====
// package: constants for the interrupt and power mode controller
package ipmc_pkg;
    localparam int          IPMC_SLOTS          = 14;
    localparam logic [15:0] IPMC_VEC_RESET      = 16'hfffe;
    localparam logic [15:0] IPMC_VEC_TRAP       = 16'hfffc;
    localparam logic [15:0] IPMC_VEC_SLOT0      = 16'hfffa;
    localparam logic [3:0]  IPMC_SLOT_EXT0      = 4'h0;
    localparam logic [3:0]  IPMC_SLOT_EXT1      = 4'h1;
    localparam logic [3:0]  IPMC_SLOT_CLK       = 4'h2;
    localparam logic [3:0]  IPMC_SLOT_SPI       = 4'h3;
    localparam logic [3:0]  IPMC_SLOT_TMRA      = 4'h4;
    localparam logic [3:0]  IPMC_SLOT_TMRB      = 4'h6;
    localparam logic [3:0]  IPMC_SLOT_TWI       = 4'hb;
    localparam logic [13:0] IPMC_USED_MASK      = 14'h085f;
    localparam logic [13:0] IPMC_HALT_WAKE_MASK = 14'h0003;
    localparam logic [5:0]  IPMC_DIV_RUN        = 6'h02;
    localparam int          IPMC_STAB_CYCLES    = 4096;
    localparam logic [1:0]  IPMC_SENS_FALL_LOW  = 2'h0;
    localparam logic [1:0]  IPMC_SENS_RISE      = 2'h1;
    localparam logic [1:0]  IPMC_SENS_FALL      = 2'h2;
    localparam logic [1:0]  IPMC_SENS_BOTH      = 2'h3;
    typedef enum logic [2:0] {
        IPMC_RUN,
        IPMC_WAIT,
        IPMC_HALT,
        IPMC_STAB,
        IPMC_VECT
    } ipmc_state_type;
endpackage

// ==== tb/ipmc_ctrl_properties.sv ====
// checker: port assertions for the interrupt and power mode controller
`timescale 1ns/100ps
module ipmc_ctrl_properties #(
    parameter int STAB_COUNT = 4096
)(
    input wire logic        i_clock,
    input wire logic        i_rst,
    input wire logic        i_trap_instr,
    input wire logic        i_vector_fetch,
    input wire logic        i_wait_for_irq_instruction,
    input wire logic        i_slow_mode_enable,
    input wire logic [1:0]  i_slow_prescaler_select,
    input wire logic        o_mask_bit,
    input wire logic        o_irq_req,
    input wire logic        o_cpu_stopped,
    input wire logic        o_osc_on,
    input wire logic        o_slow_wait,
    input wire logic [15:0] o_vector,
    input wire logic [5:0]  o_clock_div
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_rst);
    fetch_sets_mask_a: assert property (o_irq_req && i_vector_fetch |=>
        o_mask_bit && !o_irq_req) else $error("mask not set on fetch");
    trap_vector_a: assert property (i_trap_instr && !o_irq_req &&
        !o_cpu_stopped |=> o_irq_req && o_vector == 16'hfffc)
        else $error("trap vector wrong");
    run_div_a: assert property (!i_slow_mode_enable ##1
        !i_slow_mode_enable |-> o_clock_div == 6'h02)
        else $error("run divide wrong");
    slow_div_a: assert property (i_slow_mode_enable ##1
        (i_slow_mode_enable && $stable(i_slow_prescaler_select)) |->
        o_clock_div == (6'h04 << i_slow_prescaler_select))
        else $error("slow divide wrong");
    wait_mask_a: assert property (i_wait_for_irq_instruction &&
        !o_irq_req && !o_cpu_stopped |=> !o_mask_bit)
        else $error("wait did not clear mask");
    slow_wait_a: assert property (o_slow_wait |->
        o_clock_div != 6'h02) else $error("slow wait lost division");
    vector_hold_a: assert property (o_irq_req && !i_vector_fetch |=>
        o_irq_req && $stable(o_vector)) else $error("vector not held");
    legal_vector_a: assert property (o_irq_req |-> o_vector inside
        {16'hfffe, 16'hfffc, 16'hfffa, 16'hfff8, 16'hfff6, 16'hfff4,
        16'hfff2, 16'hffee, 16'hffe4}) else $error("unused vector raised");
    halt_stab_a: assert property ($rose(o_osc_on) |->
        !o_irq_req [*8]) else $error("service before stabilisation");
    cover property (o_irq_req && o_vector == 16'hfffc);
    cover property (o_irq_req && o_vector == 16'hfffa);
    cover property (o_slow_wait);
    cover property ($rose(o_osc_on));
endmodule
bind ipmc_ctrl ipmc_ctrl_properties #(.STAB_COUNT(STAB_COUNT)) u_props (.*);

// ==== tb/ipmc_cpu_model.sv ====
// model: cpu core fetching vectors after a chosen latency
`timescale 1ns/100ps
module ipmc_cpu_model (
    input  wire logic        i_clock,
    input  wire logic        i_rst,
    input  wire logic        i_irq_req,
    input  wire logic        i_boot,
    input  wire logic [15:0] i_vector,
    input  wire logic [3:0]  i_lat,
    output logic             o_fetch,
    output logic [15:0]      o_last_vector
);
    logic [3:0] cnt;
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            cnt           <= 4'h0;
            o_fetch       <= 1'b0;
            o_last_vector <= 16'h0000;
        end
        else if ((i_irq_req || i_boot) && !o_fetch)
        begin
            cnt <= (cnt == i_lat) ? 4'h0 : cnt + 4'h1;
            o_fetch <= (cnt == i_lat);
            if (cnt == i_lat)
                o_last_vector <= i_vector;
        end
        else
            o_fetch <= 1'b0;
    end
endmodule

// ==== tb/ipmc_ctrl_tb_top.sv ====
// testbench: interrupt and power mode controller
`timescale 1ns/100ps
module ipmc_ctrl_tb_top;
    import ipmc_pkg::*;
    localparam int STAB = 8;
    logic        clk = 0, rst = 1, trap = 0, wait_for_irq_instruction = 0, halt = 0, iret = 0;
    logic        slow = 0, boot = 0, mask, irq, stop, osc, swait, fetch;
    logic [7:0]  p0 = '1, p1 = '1, e0 = '0, e1 = '0;
    logic [1:0]  s0 = 2'h0, s1 = 2'h0, sel = 2'h0;
    logic [13:0] fset = '0, fen = '1, fwz = '0, sacc = '0, aacc = '0, flags;
    logic [3:0]  lat = 4'h0;
    logic [15:0] vec, last;
    logic [5:0]  div;
    int          miscompares = 0, num_checks = 0, i, n;
    int          slots[4] = '{2, 4, 6, 11};
    always #2.5 clk = ~clk;
    ipmc_ctrl #(.PINS(8), .STAB_COUNT(STAB)) dut (.i_clock(clk), .i_rst(rst),
        .i_group_zero_pins(p0), .i_group_zero_enable(e0),
        .i_group_one_pins(p1), .i_group_one_enable(e1),
        .i_group_zero_sens(s0), .i_group_one_sens(s1),
        .i_periph_flag_set(fset), .i_periph_enable(fen),
        .i_flag_write_zero(fwz), .i_status_access(sacc),
        .i_assoc_access(aacc), .i_trap_instr(trap),
        .i_wait_for_irq_instruction(wait_for_irq_instruction), .i_halt_instr(halt),
        .i_iret(iret), .i_vector_fetch(fetch), .i_slow_mode_enable(slow),
        .i_slow_prescaler_select(sel), .o_mask_bit(mask), .o_irq_req(irq),
        .o_vector(vec), .o_periph_flags(flags), .o_clock_div(div),
        .o_cpu_stopped(stop), .o_osc_on(osc), .o_slow_wait(swait));
    ipmc_cpu_model cpu (.i_clock(clk), .i_rst(rst), .i_irq_req(irq),
        .i_boot(boot), .i_vector(vec), .i_lat(lat), .o_fetch(fetch),
        .o_last_vector(last));
    task tk(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task chk(input string nm, input logic [15:0] seen, exp);
        num_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task stop_test;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task serve(input logic [15:0] exp);
        n = 0;
        while (fetch !== 1'b1 && n < 300)
        begin
            tk(1);
            n++;
        end
        if (fetch !== 1'b1)
        begin
            miscompares++;
            stop_test;
        end
        tk(1);
        chk("vector", last, exp);
    endtask
    task automatic pulse(ref logic [13:0] v, input int s);
        v[s] = 1'b1;
        tk(1);
        v = '0;
    endtask
    task ret;
        iret = 1;
        tk(1);
        iret = 0;
    endtask
    task seq_clear(input int s);
        pulse(sacc, s);
        pulse(aacc, s);
    endtask
    initial
    begin
        tk(16);
        rst = 0;
        chk("div", div, 6'h02);
        chk("vec", vec, 16'hfffe);
        boot = 1;
        serve(16'hfffe);
        boot = 0;
        pulse(fset, 3);
        tk(4);
        chk("irq", irq, 1'b0);
        ret;
        serve(16'hfff4);
        chk("mask", mask, 1'b1);
        pulse(fwz, 3);
        tk(1);
        chk("flag", flags[3], 1'b0);
        fset = 14'h3874;
        tk(1);
        fset = '0;
        for (i = 0; i < 4; i++)
        begin
            ret;
            serve(IPMC_VEC_SLOT0 - 16'(2 * slots[i]));
            if (i % 2 == 0)
                pulse(fwz, slots[i]);
            else
                seq_clear(slots[i]);
            tk(1);
            chk("flag", flags[slots[i]], 1'b0);
        end
        ret;
        tk(6);
        chk("irq", irq, 1'b0);
        $display("test peripheral done");
        fen = 14'h3ff7;
        pulse(fset, 3);
        tk(4);
        chk("irq", irq, 1'b0);
        seq_clear(3);
        fen = '1;
        tk(6);
        chk("irq", irq, 1'b0);
        trap = 1;
        tk(1);
        trap = 0;
        serve(16'hfffc);
        wait_for_irq_instruction = 1;
        tk(1);
        wait_for_irq_instruction = 0;
        tk(1);
        chk("stop", stop, 1'b1);
        chk("mask", mask, 1'b0);
        pulse(fset, 6);
        serve(16'hffee);
        chk("stop", stop, 1'b0);
        pulse(fwz, 6);
        ret;
        $display("test trap and wait done");
        s0 = IPMC_SENS_RISE;
        e0 = 8'h03;
        tk(4);
        p0[0] = 1'b0;
        serve(16'hfffa);
        ret;
        tk(8);
        chk("irq", irq, 1'b0);
        p0[1] = 1'b0;
        tk(4);
        p0[1] = 1'b1;
        tk(8);
        chk("irq", irq, 1'b0);
        p0 = '1;
        s1 = IPMC_SENS_FALL;
        p1[7] = 1'b0;
        e1 = 8'h81;
        tk(8);
        chk("irq", irq, 1'b0);
        p1[7] = 1'b1;
        serve(16'hfff8);
        ret;
        $display("test external done");
        slow = 1;
        for (i = 0; i < 4; i++)
        begin
            sel = 2'(i);
            tk(3);
            chk("div", div, 6'h04 << i);
        end
        wait_for_irq_instruction = 1;
        tk(1);
        wait_for_irq_instruction = 0;
        tk(2);
        chk("swait", swait, 1'b1);
        chk("div", div, 6'h20);
        pulse(fset, 4);
        serve(16'hfff2);
        pulse(fwz, 4);
        ret;
        slow = 0;
        tk(3);
        chk("div", div, 6'h02);
        lat = 4'h3;
        halt = 1;
        tk(1);
        halt = 0;
        pulse(fset, 3);
        tk(10);
        chk("osc", osc, 1'b0);
        p0[0] = 1'b0;
        for (n = 0; n < 50 && osc !== 1'b1; n++)
            tk(1);
        if (osc !== 1'b1)
        begin
            miscompares++;
            stop_test;
        end
        for (n = 0; n < 50 && irq !== 1'b1; n++)
            tk(1);
        if (irq !== 1'b1)
        begin
            miscompares++;
            stop_test;
        end
        chk("stab", 16'(n), 16'(STAB));
        serve(16'hfffa);
        pulse(fwz, 3);
        ret;
        $display("test halt done");
        stop_test;
    end
endmodule
